// [rtl/field_counter_consts.svh]
// Constants of the hardware field and counter block: offsets, layouts, resets
`ifndef FIELD_COUNTER_CONSTS_SVH
`define FIELD_COUNTER_CONSTS_SVH

// Field and bus widths
`define FIELD_W       16
`define ADDR_W        8
`define DATA_W        32

// Register byte offsets
`define OFS_CTRL      8'h00
`define OFS_VALUE     8'h04
`define OFS_INCR_STEP 8'h08
`define OFS_DECR_STEP 8'h0C
`define OFS_INCR_SAT  8'h10
`define OFS_DECR_SAT  8'h14
`define OFS_INCR_THR  8'h18
`define OFS_DECR_THR  8'h1C
`define OFS_STATUS    8'h20

// Control register layout
`define CTRL_W        13
`define CTRL_RESET    13'h0000

// Status register layout
`define STATUS_W      10
`define STATUS_CFGERR 9

// Reset values
`define STEP_RESET    16'h0001
`define SAT_HI_RESET  16'hFFFF
`define SAT_LO_RESET  16'h0000
`define THR_HI_RESET  16'hFFFF
`define THR_LO_RESET  16'h0000
`define VALUE_RESET   16'h0000

`endif

// [rtl/field_counter_pkg.sv]
// Types shared by the hardware field and counter block
`default_nettype none

package field_counter_pkg;

  // Hardware write enable option
  typedef enum logic [1:0] {
    WE_NONE    = 2'h0,
    WE_HIGH    = 2'h1,
    WE_LOW     = 2'h2,
    WE_INVALID = 2'h3
  } we_mode_t;

  // Per-bit update option
  typedef enum logic [1:0] {
    BIT_NONE    = 2'h0,
    BIT_ENABLE  = 2'h1,
    BIT_MASK    = 2'h2,
    BIT_INVALID = 2'h3
  } bit_mode_t;

  // Control register, bit 0 at the bottom
  typedef struct packed {
    logic      clear_on_read;
    logic      decr_thr_en;
    logic      incr_thr_en;
    logic      decr_sat_en;
    logic      incr_sat_en;
    logic      decr_step_pin;
    logic      incr_step_pin;
    logic      counter;
    logic      hw_writable;
    bit_mode_t bit_mode;
    we_mode_t  we_mode;
  } ctrl_t;

  // Single-bit field outputs
  typedef struct packed {
    logic underflow;
    logic overflow;
    logic decr_sat;
    logic incr_sat;
    logic decr_thr;
    logic incr_thr;
    logic red_xor;
    logic red_or;
    logic red_and;
  } flags_t;

endpackage : field_counter_pkg

`default_nettype wire

// [rtl/field_counter.sv]
// Hardware field with counter, set/clear, per-bit update and APB access
//
// Decided for this implementation: the APB slave port and the register offsets.
`include "field_counter_consts.svh"
`default_nettype none

// Contract
// R01 - Active-high enable gates hardware updates
// R02 - Active-low enable gates hardware updates
// R03 - Both enable polarities together is invalid
// R04 - No enable loads input every cycle
// R05 - Clear-on-read returns next value, then clears
// R06 - Without enable, read returns stored value; the read mux returns next_field in every mode
// R07 - Counter with enable counts only when enabled
// R08 - AND, OR, XOR reduction outputs
// R09 - Clear gives zeros, set gives ones
// R10 - Per-bit enable: ones take new value
// R11 - Per-bit mask: ones hold; not both
// R12 - Fixed next-state stage order
// R13 - Counter steps while its input asserted
// R14 - Default step one, static fits width
// R15 - Step-width port driven by outside logic
// R16 - External step input as wide as counter
// R17 - Step event from referenced signal, chainable
// R18 - Non-saturating counter wraps modulo width
// R19 - Saturating counter stays within limits
// R20 - Default limits are maximum and zero
// R21 - Threshold flags crossing, never limits count
// R22 - Threshold and saturate flags are outputs
// R23 - Overflow and underflow on wrap
// R24 - Threshold flags use greater/less or equal
// R25 - Clear-on-read sets field to zero
// R26 - Clear wins over set
module field_counter (
  // Clock and reset
  input  wire logic                          CLK,
  input  wire logic                          RESET,
  // APB slave
  input  wire logic                          PSEL,
  input  wire logic                          PENABLE,
  input  wire logic                          PWRITE,
  input  wire logic [`ADDR_W-1:0]            PADDR,
  input  wire logic [`DATA_W-1:0]            PWDATA,
  output logic [`DATA_W-1:0]                 PRDATA,
  output logic                               PREADY,
  output logic                               PSLVERR,
  // Hardware write side
  input  wire logic [`FIELD_W-1:0]           HW_DATA,
  input  wire logic                          HW_WE,
  input  wire logic                          HW_WE_N,
  input  wire logic                          HW_SET,
  input  wire logic                          HW_CLR,
  input  wire logic [`FIELD_W-1:0]           HW_BIT_SEL,
  // Counter events and step inputs
  input  wire logic                          INCR,
  input  wire logic                          DECR,
  input  wire logic [`FIELD_W-1:0]           INCR_STEP,
  input  wire logic [`FIELD_W-1:0]           DECR_STEP,
  // Field value and flags
  output logic [`FIELD_W-1:0]                FIELD_VALUE,
  output var field_counter_pkg::flags_t      FLAGS
);

  // Field width used throughout the datapath
  localparam int W = `FIELD_W;

  // Register match on a byte address
  function automatic logic hit(
    input logic [`ADDR_W-1:0] addr,
    input logic [`ADDR_W-1:0] ofs
  );
    hit = (addr == ofs);
  endfunction : hit

  // Known address test
  function automatic logic mapped(input logic [`ADDR_W-1:0] addr);
    mapped = hit(addr, `OFS_CTRL) | hit(addr, `OFS_VALUE)
           | hit(addr, `OFS_INCR_STEP) | hit(addr, `OFS_DECR_STEP)
           | hit(addr, `OFS_INCR_SAT) | hit(addr, `OFS_DECR_SAT)
           | hit(addr, `OFS_INCR_THR) | hit(addr, `OFS_DECR_THR)
           | hit(addr, `OFS_STATUS);
  endfunction : mapped

  // Registers, bus phases and next-state stages
  field_counter_pkg::ctrl_t ctrl;
  logic [W-1:0]             field;
  logic [W-1:0]             incr_step;
  logic [W-1:0]             decr_step;
  logic [W-1:0]             sat_hi;
  logic [W-1:0]             sat_lo;
  logic [W-1:0]             thr_hi;
  logic [W-1:0]             thr_lo;
  logic                     ack;
  logic                     access;
  logic                     wr_commit;
  logic                     rd_sample;
  logic                     sw_wr_value;
  logic                     cfg_err;
  logic                     hw_ok;
  logic                     cnt_ok;
  logic [W-1:0]             stage_we;
  logic [W-1:0]             inc_amt;
  logic [W-1:0]             dec_amt;
  logic [W+1:0]             sum;
  logic                     neg;
  logic                     over;
  logic                     ovf_ev;
  logic                     unf_ev;
  logic [W-1:0]             stage_cnt;
  logic [W-1:0]             stage_hw;
  logic [W-1:0]             upd_bits;
  logic [W-1:0]             stage_bit;
  logic [W-1:0]             next_field;
  logic [W-1:0]             sw_data;
  logic [`DATA_W-1:0]       rd_word;
  logic                     cor_clr;
  logic                     hw_force;
  logic                     sat_hi_en;
  logic                     sat_lo_en;
  logic [W-1:0]             next_store;
  field_counter_pkg::flags_t next_flags;

  // APB phases: one wait state, read captured at first access edge
  assign access      = PSEL & PENABLE;
  assign wr_commit   = access & ack & PWRITE;
  assign rd_sample   = access & ~ack & ~PWRITE;
  assign sw_wr_value = wr_commit & hit(PADDR, `OFS_VALUE);
  assign sw_data     = PWDATA[W-1:0];
  assign PREADY      = ack;
  assign PSLVERR     = ack & ~mapped(PADDR);

  // Wait-state flag, high for the completing cycle only
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
      ack <= 1'b0;
    else
      ack <= access & ~ack;
  end

  // Invalid option combinations block hardware loads and counting
  assign cfg_err = (ctrl.we_mode == field_counter_pkg::WE_INVALID)
                 | (ctrl.bit_mode == field_counter_pkg::BIT_INVALID); // R03 R11

  // Stage 1: write enable qualification
  always_comb
  begin
    case (ctrl.we_mode)
      field_counter_pkg::WE_NONE:  hw_ok = 1'b1;      // R04
      field_counter_pkg::WE_HIGH:  hw_ok = HW_WE;     // R01
      field_counter_pkg::WE_LOW:   hw_ok = ~HW_WE_N;  // R02
      default:                     hw_ok = 1'b0;      // R03
    endcase
  end

  // Stage 1: hardware load of a plain field
  always_comb
  begin
    if (ctrl.hw_writable & ~ctrl.counter & hw_ok & ~cfg_err)
      stage_we = HW_DATA; // R04 R12
    else
      stage_we = field;
  end

  // Counter steps only when the write enable allows
  assign cnt_ok = ctrl.counter & hw_ok & ~cfg_err; // R07

  // Step amounts from register or from the step ports
  always_comb
  begin
    inc_amt = '0;
    dec_amt = '0;
    if (cnt_ok & INCR) // R13 R17
      inc_amt = ctrl.incr_step_pin ? INCR_STEP : incr_step; // R14 R15 R16
    if (cnt_ok & DECR) // R13 R17
      dec_amt = ctrl.decr_step_pin ? DECR_STEP : decr_step; // R14 R15 R16
  end

  // Two extra bits expose wrap in either direction
  assign sum  = {2'b00, stage_we} + {2'b00, inc_amt} - {2'b00, dec_amt};
  assign neg  = sum[W+1];
  assign over = ~neg & sum[W];

  // Saturation limits a counter only, never a plain field
  assign sat_hi_en = ctrl.counter & ctrl.incr_sat_en; // R19 R20
  assign sat_lo_en = ctrl.counter & ctrl.decr_sat_en; // R19 R20

  // Stage 2: saturation or modulo wrap
  always_comb
  begin
    ovf_ev    = 1'b0;
    unf_ev    = 1'b0;
    stage_cnt = sum[W-1:0]; // R18
    if (sat_hi_en & ~neg & (sum > {2'b00, sat_hi}))
      stage_cnt = sat_hi; // R19
    else if (sat_lo_en & (neg | (sum < {2'b00, sat_lo})))
      stage_cnt = sat_lo; // R19
    else
    begin
      ovf_ev = over; // R23
      unf_ev = neg;  // R23
    end
  end

  // Either force input keeps a wrap pulse from being reported
  assign hw_force = HW_CLR | HW_SET; // R09

  // Stage 2: hardware set and clear, clear first
  always_comb
  begin
    if (HW_CLR)
      stage_hw = '0; // R09 R26
    else if (HW_SET)
      stage_hw = '1; // R09
    else
      stage_hw = stage_cnt; // R12
  end

  // Per-bit update selection
  always_comb
  begin
    case (ctrl.bit_mode)
      field_counter_pkg::BIT_NONE:   upd_bits = '1;
      field_counter_pkg::BIT_ENABLE: upd_bits = HW_BIT_SEL;  // R10
      field_counter_pkg::BIT_MASK:   upd_bits = ~HW_BIT_SEL; // R11
      default:                       upd_bits = '0;          // R11
    endcase
  end

  // Bits not selected keep their stored value
  genvar b;
  generate
    for (b = 0; b < W; b++)
    begin : g_bit
      assign stage_bit[b] = upd_bits[b] ? stage_hw[b] : field[b]; // R10 R11
    end
  endgenerate

  // Stage 3: software write takes the field over hardware
  assign next_field = sw_wr_value ? sw_data : stage_bit; // R12

  // Clear-on-read of the value register overrides every other update
  assign cor_clr    = rd_sample & hit(PADDR, `OFS_VALUE) & ctrl.clear_on_read; // R05
  assign next_store = cor_clr ? '0 : next_field; // R25

  // Stage 4: field storage, clear-on-read to zero
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
      field <= `VALUE_RESET;
    else
      field <= next_store; // R12
  end

  // Field value straight from its flip-flops
  assign FIELD_VALUE = field;

  // Control register
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
      ctrl <= `CTRL_RESET;
    else if (wr_commit & hit(PADDR, `OFS_CTRL))
      ctrl <= PWDATA[`CTRL_W-1:0];
  end

  // Step values, default one
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      incr_step <= `STEP_RESET; // R14
      decr_step <= `STEP_RESET; // R14
    end
    else
    begin
      if (wr_commit & hit(PADDR, `OFS_INCR_STEP))
        incr_step <= sw_data;
      if (wr_commit & hit(PADDR, `OFS_DECR_STEP))
        decr_step <= sw_data;
    end
  end

  // Saturation limits, default maximum and zero
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      sat_hi <= `SAT_HI_RESET; // R20
      sat_lo <= `SAT_LO_RESET; // R20
    end
    else
    begin
      if (wr_commit & hit(PADDR, `OFS_INCR_SAT))
        sat_hi <= sw_data;
      if (wr_commit & hit(PADDR, `OFS_DECR_SAT))
        sat_lo <= sw_data;
    end
  end

  // Threshold values
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      thr_hi <= `THR_HI_RESET;
      thr_lo <= `THR_LO_RESET;
    end
    else
    begin
      if (wr_commit & hit(PADDR, `OFS_INCR_THR))
        thr_hi <= sw_data;
      if (wr_commit & hit(PADDR, `OFS_DECR_THR))
        thr_lo <= sw_data;
    end
  end

  // Flags of the value about to be stored; wrap pulses only on a real count
  always_comb
  begin
    next_flags.red_and   = &next_store; // R08
    next_flags.red_or    = |next_store; // R08
    next_flags.red_xor   = ^next_store; // R08
    next_flags.incr_thr  = ctrl.incr_thr_en & (next_store >= thr_hi); // R21 R22 R24
    next_flags.decr_thr  = ctrl.decr_thr_en & (next_store <= thr_lo); // R21 R22 R24
    next_flags.incr_sat  = ctrl.incr_sat_en & (next_store >= sat_hi); // R22
    next_flags.decr_sat  = ctrl.decr_sat_en & (next_store <= sat_lo); // R22
    next_flags.overflow  = ovf_ev & ~sw_wr_value & ~hw_force & ~cor_clr; // R23
    next_flags.underflow = unf_ev & ~sw_wr_value & ~hw_force & ~cor_clr; // R23
  end

  // Flags registered alongside the stored field
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
      FLAGS <= '0;
    else
      FLAGS <= next_flags;
  end

  // Read mux; the field view returns the next value ahead of clear-on-read
  always_comb
  begin
    rd_word = '0;
    case (PADDR)
      `OFS_CTRL:      rd_word[`CTRL_W-1:0] = ctrl;
      `OFS_VALUE:     rd_word[W-1:0] = next_field; // R05 R06
      `OFS_INCR_STEP: rd_word[W-1:0] = incr_step;
      `OFS_DECR_STEP: rd_word[W-1:0] = decr_step;
      `OFS_INCR_SAT:  rd_word[W-1:0] = sat_hi;
      `OFS_DECR_SAT:  rd_word[W-1:0] = sat_lo;
      `OFS_INCR_THR:  rd_word[W-1:0] = thr_hi;
      `OFS_DECR_THR:  rd_word[W-1:0] = thr_lo;
      `OFS_STATUS:
      begin
        rd_word[`STATUS_W-2:0]  = FLAGS;
        rd_word[`STATUS_CFGERR] = cfg_err;
      end
      default:        rd_word = '0;
    endcase
  end

  // Read data held in a flop through the completing cycle
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
      PRDATA <= '0;
    else if (rd_sample)
      PRDATA <= rd_word;
  end

endmodule : field_counter

`default_nettype wire

// [bench/field_counter_chk.sv]
// Checker for the hardware field block, watching its top-level ports
`include "field_counter_consts.svh"
`default_nettype none
module field_counter_chk (
  // Clock and reset
  input wire logic                      CLK,
  input wire logic                      RESET,
  // APB
  input wire logic                      PSEL,
  input wire logic                      PENABLE,
  input wire logic                      PWRITE,
  input wire logic [`ADDR_W-1:0]        PADDR,
  input wire logic [`DATA_W-1:0]        PWDATA,
  input wire logic                      PREADY,
  // Hardware side
  input wire logic [`FIELD_W-1:0]       HW_DATA,
  input wire logic                      HW_WE,
  input wire logic                      HW_WE_N,
  input wire logic                      HW_SET,
  input wire logic                      HW_CLR,
  input wire logic [`FIELD_W-1:0]       HW_BIT_SEL,
  input wire logic                      INCR,
  input wire logic                      DECR,
  input wire logic [`FIELD_W-1:0]       INCR_STEP,
  // Field
  input wire logic [`FIELD_W-1:0]       FIELD_VALUE,
  input wire field_counter_pkg::flags_t FLAGS
);
  timeunit 1ns;
  timeprecision 1ps;
  field_counter_pkg::ctrl_t ctrl;
  logic                     quiet;
  logic                     nobits;
  logic                     carry;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);

  // Shadow of the control register, loaded at the committing edge of a write
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
      ctrl <= '0;
    else if (PSEL && PENABLE && PWRITE && PREADY && PADDR == `OFS_CTRL)
      ctrl <= field_counter_pkg::ctrl_t'(PWDATA[`CTRL_W-1:0]);
  end

  // No bus access and no force; all bits updatable; carry of an up step
  assign quiet  = !PSEL && !HW_SET && !HW_CLR;
  assign nobits = ctrl.bit_mode == field_counter_pkg::BIT_NONE;
  assign carry  = ({1'h0, FIELD_VALUE} + {1'h0, INCR_STEP}) > 17'h0FFFF;

  property p_red;
    FLAGS.red_and == &FIELD_VALUE && FLAGS.red_or == |FIELD_VALUE && FLAGS.red_xor == ^FIELD_VALUE;
  endproperty
  a_red: assert property (p_red) else $error("reduction flag wrong");
  property p_clr;
    HW_CLR && !PSEL && nobits |=> FIELD_VALUE == 16'h0000;
  endproperty
  a_clr: assert property (p_clr) else $error("clear did not zero");
  property p_set;
    HW_SET && !HW_CLR && !PSEL && nobits |=> FIELD_VALUE == 16'hFFFF;
  endproperty
  a_set: assert property (p_set) else $error("set did not fill");
  property p_we;
    ctrl.we_mode == field_counter_pkg::WE_HIGH && !HW_WE && quiet |=> $stable(FIELD_VALUE);
  endproperty
  a_we: assert property (p_we) else $error("moved without enable");
  property p_wel;
    ctrl.we_mode == field_counter_pkg::WE_LOW && HW_WE_N && quiet |=> $stable(FIELD_VALUE);
  endproperty
  a_wel: assert property (p_wel) else $error("moved without low enable");
  property p_load;
    ctrl.hw_writable && !ctrl.counter && ctrl.we_mode == field_counter_pkg::WE_NONE
      && nobits && quiet |=> FIELD_VALUE == $past(HW_DATA);
  endproperty
  a_load: assert property (p_load) else $error("no load every cycle");
  property p_mask;
    ctrl.bit_mode == field_counter_pkg::BIT_MASK && !PSEL
      |=> ((FIELD_VALUE ^ $past(FIELD_VALUE)) & $past(HW_BIT_SEL)) == 16'h0000;
  endproperty
  a_mask: assert property (p_mask) else $error("masked bit changed");
  property p_step;
    ctrl.counter && ctrl.incr_step_pin && !ctrl.incr_sat_en && nobits && INCR && !DECR
      && ctrl.we_mode == field_counter_pkg::WE_NONE && quiet
      |=> FIELD_VALUE == $past(FIELD_VALUE) + $past(INCR_STEP) && FLAGS.overflow == $past(carry);
  endproperty
  a_step: assert property (p_step) else $error("step or overflow wrong");
endmodule : field_counter_chk
`default_nettype wire

// [bench/low_counter.sv]
// Partner model: lower stage of a chained counter supplying the step event
`default_nettype none
module low_counter (
  // Clock and reset
  input  wire logic CLK,
  input  wire logic RESET,
  // Bench control: run counts, burst gives an event every run cycle
  input  wire logic run,
  input  wire logic burst,
  // Step event into the upper field
  output logic      carry
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt;

  // Lower count; registered carry changes just after the edge
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      cnt   <= 2'h0;
      carry <= 1'h0;
    end
    else
    begin
      cnt   <= cnt + {1'h0, run};
      carry <= run && (burst || cnt == 2'h3);
    end
  end
endmodule : low_counter
`default_nettype wire

// [bench/tb_field_counter.sv]
// Testbench for the hardware field block: APB, hardware pins and counter
`include "field_counter_consts.svh"
`default_nettype none
module tb_field_counter;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CLK, PREADY, PSLVERR, INCR, err;
  logic        RESET = 1'h1, PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0;
  logic        HW_WE = 1'h0, HW_WE_N = 1'h1, HW_SET = 1'h0, HW_CLR = 1'h0;
  logic        DECR = 1'h0, run = 1'h0, burst = 1'h1;
  logic [7:0]  PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h00000000, PRDATA, rd;
  logic [15:0] HW_DATA = 16'h0000, HW_BIT_SEL = 16'h0000, FIELD_VALUE;
  logic [15:0] INCR_STEP = 16'h0001, DECR_STEP = 16'h0001;
  field_counter_pkg::flags_t FLAGS;
  int          mismatches = 0, checks = 0;

  // Design and the lower counter stage that feeds its step event
  field_counter u_dut (.CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .HW_DATA(HW_DATA), .HW_WE(HW_WE), .HW_WE_N(HW_WE_N),
    .HW_SET(HW_SET), .HW_CLR(HW_CLR), .HW_BIT_SEL(HW_BIT_SEL), .INCR(INCR), .DECR(DECR),
    .INCR_STEP(INCR_STEP), .DECR_STEP(DECR_STEP), .FIELD_VALUE(FIELD_VALUE), .FLAGS(FLAGS));
  low_counter u_src (.CLK(CLK), .RESET(RESET), .run(run), .burst(burst), .carry(INCR));

  // 125 MHz clock
  initial
  begin
    CLK = 1'h0;
    forever #4 CLK = ~CLK;
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic nx;
    @(posedge CLK);
    #1;
  endtask : nx

  // One APB transfer; read data and error taken at the completing edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    PSEL <= 1'h1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'h1;
    do
      @(posedge CLK);
    while (PREADY !== 1'h1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
  endtask : apb

  // One step event from the partner stage
  task automatic bump;
    @(posedge CLK);
    run <= 1'h1;
    @(posedge CLK);
    run <= 1'h0;
    nx();
  endtask : bump

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic t_regs;
    apb(1'h0, `OFS_INCR_STEP, 32'h0);
    chk("incr_step", rd, 32'h1);
    apb(1'h0, `OFS_INCR_SAT, 32'h0);
    chk("incr_sat", rd, 32'hFFFF);
    apb(1'h0, 8'h24, 32'h0);
    chk("unmapped", {err, rd[30:0]}, 32'h80000000);
    apb(1'h1, `OFS_CTRL, 32'h3);
    apb(1'h0, `OFS_STATUS, 32'h0);
    chk("cfg_err", rd, 32'h200);
    apb(1'h1, `OFS_CTRL, 32'h0);
  endtask : t_regs

  task automatic t_setclr;
    @(posedge CLK);
    HW_SET <= 1'h1;
    @(posedge CLK);
    HW_CLR <= 1'h1;
    #1;
    chk("set", {FIELD_VALUE, FLAGS.red_and}, {16'hFFFF, 1'h1});
    @(posedge CLK);
    HW_SET <= 1'h0;
    HW_CLR <= 1'h0;
    #1;
    chk("clr_wins", FIELD_VALUE, 32'h0);
  endtask : t_setclr

  task automatic t_we;
    apb(1'h1, `OFS_CTRL, 32'h11);
    @(posedge CLK);
    HW_DATA <= 16'h1234;
    nx();
    nx();
    chk("we_off", FIELD_VALUE, 32'h0);
    @(posedge CLK);
    HW_WE <= 1'h1;
    nx();
    chk("we_on", FIELD_VALUE, 32'h1234);
    apb(1'h1, `OFS_CTRL, 32'h12);
    @(posedge CLK);
    HW_DATA <= 16'h5678;
    nx();
    nx();
    chk("wel_off", FIELD_VALUE, 32'h1234);
    @(posedge CLK);
    HW_WE_N <= 1'h0;
    nx();
    chk("wel_on", FIELD_VALUE, 32'h5678);
    apb(1'h1, `OFS_CTRL, 32'h10);
    @(posedge CLK);
    HW_DATA <= 16'h9ABC;
    nx();
    chk("no_we", FIELD_VALUE, 32'h9ABC);
  endtask : t_we

  task automatic t_bits;
    apb(1'h1, `OFS_CTRL, 32'h14);
    @(posedge CLK);
    HW_DATA <= 16'h0000;
    HW_BIT_SEL <= 16'h00FF;
    nx();
    chk("bit_en", FIELD_VALUE, 32'h9A00);
    apb(1'h1, `OFS_CTRL, 32'h18);
    @(posedge CLK);
    HW_DATA <= 16'hFFFF;
    nx();
    chk("bit_mask", FIELD_VALUE, 32'hFF00);
  endtask : t_bits

  task automatic t_count;
    apb(1'h1, `OFS_CTRL, 32'hF0);
    apb(1'h1, `OFS_VALUE, 32'hFFFE);
    @(posedge CLK);
    INCR_STEP <= 16'h0003;
    bump();
    chk("wrap", {FIELD_VALUE, FLAGS.overflow}, {16'h0001, 1'h1});
    nx();
    chk("ovf_once", FLAGS.overflow, 32'h0);
    @(posedge CLK);
    DECR_STEP <= 16'h0002;
    DECR <= 1'h1;
    @(posedge CLK);
    DECR <= 1'h0;
    #1;
    chk("under", {FIELD_VALUE, FLAGS.underflow}, {16'hFFFF, 1'h1});
  endtask : t_count

  task automatic t_limit;
    apb(1'h1, `OFS_CTRL, 32'h1F0);
    apb(1'h1, `OFS_VALUE, 32'hFFFE);
    bump();
    chk("sat", {FIELD_VALUE, FLAGS.incr_sat, FLAGS.overflow}, {16'hFFFF, 2'h2});
    apb(1'h1, `OFS_CTRL, 32'h4F0);
    apb(1'h1, `OFS_INCR_THR, 32'h10);
    apb(1'h1, `OFS_VALUE, 32'hE);
    @(posedge CLK);
    INCR_STEP <= 16'h0002;
    #1;
    chk("thr_below", FLAGS.incr_thr, 32'h0);
    bump();
    chk("thr_equal", {FIELD_VALUE, FLAGS.incr_thr}, {16'h0010, 1'h1});
    bump();
    chk("thr_nolimit", {FIELD_VALUE, FLAGS.incr_thr}, {16'h0012, 1'h1});
    apb(1'h1, `OFS_CTRL, 32'hAF0);
    apb(1'h1, `OFS_VALUE, 32'h1);
    @(posedge CLK);
    DECR <= 1'h1;
    @(posedge CLK);
    DECR <= 1'h0;
    #1;
    chk("dsat", {FIELD_VALUE, FLAGS.underflow}, {16'h0000, 1'h0});
    chk("dflags", {FLAGS.decr_sat, FLAGS.decr_thr}, 32'h3);
  endtask : t_limit

  task automatic t_cor;
    apb(1'h1, `OFS_CTRL, 32'h1000);
    apb(1'h1, `OFS_VALUE, 32'h5);
    apb(1'h0, `OFS_VALUE, 32'h0);
    chk("cor_read", rd, 32'h5);
    nx();
    chk("cor_zero", FIELD_VALUE, 32'h0);
    apb(1'h1, `OFS_CTRL, 32'h1010);
    fork
      apb(1'h0, `OFS_VALUE, 32'h0);
      begin
        repeat (2) @(posedge CLK);
        HW_DATA <= 16'h0042;
      end
    join
    chk("cor_next", rd, 32'h42);
  endtask : t_cor

  task automatic t_chain;
    apb(1'h1, `OFS_CTRL, 32'h30);
    apb(1'h1, `OFS_VALUE, 32'h0);
    @(posedge CLK);
    burst <= 1'h0;
    run <= 1'h1;
    repeat (8) @(posedge CLK);
    run <= 1'h0;
    nx();
    nx();
    chk("chain", FIELD_VALUE, 32'h2);
  endtask : t_chain

  // Main sequence
  initial
  begin
    repeat (20) @(posedge CLK);
    RESET <= 1'h0;
    t_regs();
    $display("regs done");
    t_setclr();
    $display("setclr done");
    t_we();
    $display("we done");
    t_bits();
    $display("bits done");
    t_count();
    $display("count done");
    t_limit();
    $display("limit done");
    t_cor();
    $display("cor done");
    t_chain();
    $display("chain done");
    tally_and_finish();
  end

  // Watchdog
  initial
  begin
    repeat (5000) @(posedge CLK);
    mismatches++;
    tally_and_finish();
  end
endmodule : tb_field_counter

bind field_counter field_counter_chk u_chk (.CLK(CLK), .RESET(RESET), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
  .HW_DATA(HW_DATA), .HW_WE(HW_WE), .HW_WE_N(HW_WE_N), .HW_SET(HW_SET), .HW_CLR(HW_CLR),
  .HW_BIT_SEL(HW_BIT_SEL), .INCR(INCR), .DECR(DECR), .INCR_STEP(INCR_STEP),
  .FIELD_VALUE(FIELD_VALUE), .FLAGS(FLAGS));
`default_nettype wire
